// *** include/cpme_pkg.sv ***
// constants and types of the pdo mapping engine
`default_nettype none
package cpme_pkg;
	localparam int NUM_PDO = 8;
	localparam int MAX_BITS = 64;
	localparam logic [15:0] IDX_RX_COMM = 16'h1400;
	localparam logic [15:0] IDX_RX_MAP = 16'h1600;
	localparam logic [15:0] IDX_TX_COMM = 16'h1800;
	localparam logic [15:0] IDX_TX_MAP = 16'h1A00;
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_COBID = 8'h01;
	localparam logic [7:0] SUB_TTYPE = 8'h02;
	localparam logic [7:0] SUB_INHIBIT = 8'h03;
	localparam logic [7:0] SUB_EVENT = 8'h05;
	localparam logic [7:0] RX_COMM_SUBS = 8'h02;
	localparam logic [7:0] TX_COMM_SUBS = 8'h05;
	localparam logic [7:0] MAX_ENTRY = 8'h0F;
	localparam int VALID_BIT = 31;
	localparam logic [31:0] COBID_RESET = 32'h80000000;
	localparam logic [7:0] TTYPE_RESET = 8'hFF;
	localparam logic [7:0] TT_ACYCLIC = 8'h00;
	localparam logic [7:0] TT_SYNC_MAX = 8'hF0;
	localparam logic [7:0] TT_TX_RSV_MAX = 8'hFB;
	localparam logic [7:0] TT_RTR_SYNC = 8'hFC;
	localparam logic [7:0] TT_RTR_EVT = 8'hFD;
	localparam logic [7:0] TT_RX_RSV_MAX = 8'hFD;
	localparam logic [7:0] TT_ASYNC = 8'hFE;
	localparam logic [10:0] RX_BASE [4] = '{11'h200, 11'h300, 11'h400, 11'h500};
	localparam logic [10:0] TX_BASE [4] = '{11'h180, 11'h280, 11'h380, 11'h480};
	localparam logic [31:0] ABORT_NONE = 32'h00000000;
	localparam logic [31:0] ABORT_RDONLY = 32'h06010002;
	localparam logic [31:0] ABORT_NOOBJ = 32'h06020000;
	localparam logic [31:0] ABORT_EXCEED = 32'h06040042;
	localparam logic [31:0] ABORT_NOSUB = 32'h06090011;
	localparam logic [31:0] ABORT_VALUE = 32'h06090031;
	localparam logic [31:0] ABORT_GENERAL = 32'h08000000;
	localparam logic [31:0] ABORT_STATE = 32'h08000022;
	localparam int CLK_HZ = 40000000;
	localparam int TICK_US = 100;
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam int TICKS_PER_MS = 1000 / TICK_US;
	localparam logic [1:0] BOOT_WAIT = 2'h3;
	typedef enum logic [2:0] {
		W_IDLE = 3'b001,
		W_READ = 3'b010,
		W_DATA = 3'b100
	} cpme_walk_t;
endpackage : cpme_pkg
`default_nettype wire

// *** design/cpme_entry_mem.sv ***
// mapping entry memory with registered read port
`default_nettype none
module cpme_entry_mem #(
	parameter int WIDTH = 32,
	parameter int ADDR_W = 8
) (
	input wire logic ref_clk,
	input wire logic we,
	input wire logic [ADDR_W-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic re,
	input wire logic [ADDR_W-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [2**ADDR_W];

	always_ff @(posedge ref_clk) begin
		if (we) mem[waddr] <= wdata;
		if (re) rdata <= mem[raddr];
	end
endmodule : cpme_entry_mem
`default_nettype wire

// *** design/cpme_engine.sv ***
// pdo mapping engine: object access, receive commit and transmit scheduling
`default_nettype none
//
// Contract
// - process data only in operational state
// - eight rx, eight tx, 64-bit payload
// - rx link params have three subindices
// - rx ids one-four fixed base plus node
// - bit 31 validity flag always writable; code refuses it while operational, as with every write
// - new identifier used only after restart
// - sync types buffer until next sync
// - types FE, FF commit on reception
// - entry count zero disables mapping
// - entries hold index, subindex, bit length
// - payload bits assigned to entries in order
// - tx ids one-four fixed base plus node
// - event: operational entry, change, timer
// - event timer restarts only on expiry
// - type zero: capture sync, send event
// - types 1-240 send every nth sync
// - type FC: capture sync, send remote
// - type FD captures and sends on remote
// - types FE, FF capture, send on event
// - asynchronous inhibit gap in 100 us steps
// - subindex four inert, five event ms
// - writes refused while operational
// - mapping beyond eight bytes aborted
module cpme_engine (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [6:0] nodeIdPin,
	input wire logic opState,
	input wire logic commRestart,
	input wire logic odWrite,
	input wire logic odRead,
	input wire logic [15:0] odIndex,
	input wire logic [7:0] odSub,
	input wire logic [31:0] odWdata,
	output logic odDone,
	output logic [31:0] odRdata,
	output logic [31:0] odAbort,
	input wire logic rxValid,
	input wire logic [10:0] rxId,
	input wire logic rxRtr,
	input wire logic [63:0] rxData,
	input wire logic syncSeen,
	input wire logic [511:0] txObjData,
	output logic txValid,
	input wire logic txReady,
	output logic [10:0] txId,
	output logic [3:0] txLen,
	output logic [63:0] txData,
	output logic commitValid,
	output logic [15:0] commitIndex,
	output logic [7:0] commitSub,
	output logic [7:0] commitBits,
	output logic [63:0] commitData
);
	// ----------------------------------------
	// object access and configuration
	// ----------------------------------------
	logic [6:0] nodeSync1, nodeId;
	logic [31:0] cobId [16], next_cobId [16];
	logic [7:0] ttype [16], next_ttype [16];
	logic [7:0] mapCnt [16], next_mapCnt [16];
	logic [7:0] entBits [16][15], next_entBits [16][15];
	logic [15:0] inhibit [8], next_inhibit [8];
	logic [15:0] evtMs [8], next_evtMs [8];
	logic [10:0] actId [16], next_actId [16];
	logic [1:0] bootCnt, next_bootCnt;
	logic reqV, reqWr, reqComm, reqMap, restartLd, memWe, ttRsv, odMapRd, walkRd;
	logic [15:0] reqIdx;
	logic [7:0] reqSub, reqTop;
	logic [31:0] reqData, next_rdata, next_abort, memQ;
	logic [3:0] reqM;
	logic [11:0] newSum;

	function automatic logic [10:0] fixedId(input logic [3:0] m, input logic [6:0] node);
		fixedId = (m[3] ? cpme_pkg::TX_BASE[m[1:0]] : cpme_pkg::RX_BASE[m[1:0]]) + {4'h0, node};
	endfunction : fixedId

	assign reqComm = reqIdx[15:3] == cpme_pkg::IDX_RX_COMM[15:3]
		|| reqIdx[15:3] == cpme_pkg::IDX_TX_COMM[15:3];
	assign reqMap = reqIdx[15:3] == cpme_pkg::IDX_RX_MAP[15:3]
		|| reqIdx[15:3] == cpme_pkg::IDX_TX_MAP[15:3];
	assign reqM = {reqIdx[11], reqIdx[2:0]};
	assign reqTop = reqMap ? cpme_pkg::MAX_ENTRY
		: (reqM[3] ? cpme_pkg::TX_COMM_SUBS : cpme_pkg::RX_COMM_SUBS);
	assign ttRsv = reqData[7:0] > cpme_pkg::TT_SYNC_MAX && reqData[7:0] <= (reqM[3]
		? cpme_pkg::TT_TX_RSV_MAX : cpme_pkg::TT_RX_RSV_MAX);
	assign restartLd = commRestart || bootCnt != cpme_pkg::BOOT_WAIT;
	assign odMapRd = odRead && odSub != cpme_pkg::SUB_COUNT && odSub <= cpme_pkg::MAX_ENTRY
		&& (odIndex[15:3] == cpme_pkg::IDX_RX_MAP[15:3]
		|| odIndex[15:3] == cpme_pkg::IDX_TX_MAP[15:3]);

	always_comb begin
		next_cobId = cobId;
		next_ttype = ttype;
		next_mapCnt = mapCnt;
		next_entBits = entBits;
		next_inhibit = inhibit;
		next_evtMs = evtMs;
		next_actId = actId;
		next_bootCnt = bootCnt;
		next_rdata = '0;
		next_abort = cpme_pkg::ABORT_NONE;
		memWe = 1'b0;
		newSum = '0;
		for (int i = 0; i < 15; i++) begin
			if (8'(i) < reqData[7:0]) newSum = newSum + {4'h0, entBits[reqM][i]};
		end
		if (reqV) begin
			if (!reqComm && !reqMap) begin
				next_abort = cpme_pkg::ABORT_NOOBJ;
			end else if (reqSub > reqTop) begin
				next_abort = cpme_pkg::ABORT_NOSUB;
			end else if (!reqWr) begin
				if (reqMap) begin
					next_rdata = reqSub == cpme_pkg::SUB_COUNT ? {24'h0, mapCnt[reqM]} : memQ;
				end else begin
					case (reqSub)
						cpme_pkg::SUB_COUNT: next_rdata = {24'h0, reqTop};
						cpme_pkg::SUB_COBID: next_rdata = reqM[2] ? cobId[reqM]
							: {cobId[reqM][31], 20'h0, fixedId(reqM, nodeId)};
						cpme_pkg::SUB_TTYPE: next_rdata = {24'h0, ttype[reqM]};
						cpme_pkg::SUB_INHIBIT: next_rdata = {16'h0, inhibit[reqM[2:0]]};
						cpme_pkg::SUB_EVENT: next_rdata = {16'h0, evtMs[reqM[2:0]]};
						default: next_rdata = '0;
					endcase
				end
			end else if (opState) begin
				next_abort = cpme_pkg::ABORT_STATE;
			end else if (reqComm) begin
				case (reqSub)
					cpme_pkg::SUB_COUNT: next_abort = cpme_pkg::ABORT_RDONLY;
					cpme_pkg::SUB_COBID: begin
						next_cobId[reqM][cpme_pkg::VALID_BIT] = reqData[cpme_pkg::VALID_BIT];
						if (reqM[2]) next_cobId[reqM] = reqData;
					end
					cpme_pkg::SUB_TTYPE: begin
						if (ttRsv) next_abort = cpme_pkg::ABORT_GENERAL;
						else next_ttype[reqM] = reqData[7:0];
					end
					cpme_pkg::SUB_INHIBIT: next_inhibit[reqM[2:0]] = reqData[15:0];
					cpme_pkg::SUB_EVENT: next_evtMs[reqM[2:0]] = reqData[15:0];
					default: next_abort = cpme_pkg::ABORT_NONE;
				endcase
			end else if (reqSub == cpme_pkg::SUB_COUNT) begin
				if (reqData[7:0] > cpme_pkg::MAX_ENTRY) next_abort = cpme_pkg::ABORT_VALUE;
				else if (newSum > 12'(cpme_pkg::MAX_BITS)) next_abort = cpme_pkg::ABORT_EXCEED;
				else next_mapCnt[reqM] = reqData[7:0];
			end else begin
				memWe = 1'b1;
				next_entBits[reqM][reqSub[3:0] - 4'h1] = reqData[7:0];
			end
		end
		if (restartLd) begin
			for (int j = 0; j < 16; j++) begin
				next_actId[j] = j[2] ? next_cobId[j][10:0] : fixedId(4'(j), nodeId);
			end
		end
		if (bootCnt != cpme_pkg::BOOT_WAIT) next_bootCnt = bootCnt + 2'h1;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 16; i++) begin
				cobId[i] <= cpme_pkg::COBID_RESET;
				ttype[i] <= cpme_pkg::TTYPE_RESET;
				mapCnt[i] <= '0;
				actId[i] <= '0;
				for (int e = 0; e < 15; e++) entBits[i][e] <= '0;
			end
			for (int i = 0; i < 8; i++) begin
				inhibit[i] <= '0;
				evtMs[i] <= '0;
			end
			{nodeSync1, nodeId, bootCnt, reqV, reqWr, reqIdx, reqSub, reqData} <= '0;
			{odDone, odRdata, odAbort} <= '0;
		end else begin
			cobId <= next_cobId;
			ttype <= next_ttype;
			mapCnt <= next_mapCnt;
			entBits <= next_entBits;
			inhibit <= next_inhibit;
			evtMs <= next_evtMs;
			actId <= next_actId;
			bootCnt <= next_bootCnt;
			nodeSync1 <= nodeIdPin;
			nodeId <= nodeSync1;
			reqV <= odWrite || odRead;
			reqWr <= odWrite;
			reqIdx <= odIndex;
			reqSub <= odSub;
			reqData <= odWdata;
			odDone <= reqV;
			odRdata <= next_rdata;
			odAbort <= next_abort;
		end
	end

	// ----------------------------------------
	// receive buffering and commit walk
	// ----------------------------------------
	cpme_pkg::cpme_walk_t wState, next_wState;
	logic [2:0] wMap, next_wMap;
	logic [3:0] wEnt, next_wEnt;
	logic [7:0] wOff, next_wOff, rxHit, rxHeld, next_rxHeld, rxPend, next_rxPend;
	logic [63:0] wData, next_wData, wMask;
	logic [63:0] rxBuf [8], next_rxBuf [8];
	logic next_cValid;
	logic [63:0] next_cData;

	cpme_entry_mem #(.WIDTH(32), .ADDR_W(8)) u_mem (
		.ref_clk(ref_clk),
		.we(memWe),
		.waddr({reqM, reqSub[3:0]}),
		.wdata(reqData),
		.re(odMapRd || walkRd),
		.raddr(odMapRd ? {odIndex[11], odIndex[2:0], odSub[3:0]} : {1'b0, wMap, wEnt + 4'h1}),
		.rdata(memQ)
	);

	assign walkRd = wState == cpme_pkg::W_READ && !odMapRd;

	always_comb begin
		next_wState = wState;
		next_wMap = wMap;
		next_wEnt = wEnt;
		next_wOff = wOff;
		next_wData = wData;
		next_rxBuf = rxBuf;
		next_rxHeld = rxHeld;
		next_rxPend = rxPend;
		next_cValid = 1'b0;
		next_cData = commitData;
		wMask = memQ[7:0] >= 8'(cpme_pkg::MAX_BITS) ? '1 : (64'h1 << memQ[7:0]) - 64'h1;
		case (wState)
			cpme_pkg::W_IDLE: begin
				if (rxPend != 8'h00) begin
					for (int n = 7; n >= 0; n--) begin
						if (rxPend[n]) next_wMap = 3'(n);
					end
					next_wData = rxBuf[next_wMap];
					next_rxPend[next_wMap] = 1'b0;
					next_wEnt = '0;
					next_wOff = '0;
					next_wState = cpme_pkg::W_READ;
				end
			end
			cpme_pkg::W_READ: if (walkRd) next_wState = cpme_pkg::W_DATA;
			cpme_pkg::W_DATA: begin
				next_cValid = 1'b1;
				next_cData = (wData >> wOff) & wMask;
				next_wOff = wOff + memQ[7:0];
				next_wEnt = wEnt + 4'h1;
				next_wState = wEnt + 4'h1 >= mapCnt[{1'b0, wMap}][3:0] ? cpme_pkg::W_IDLE
					: cpme_pkg::W_READ;
			end
			default: next_wState = cpme_pkg::W_IDLE;
		endcase
		if (syncSeen) begin
			next_rxPend = next_rxPend | rxHeld;
			next_rxHeld = '0;
		end
		for (int n = 0; n < 8; n++) begin
			rxHit[n] = rxValid && !rxRtr && rxId == actId[n] && opState
				&& !cobId[n][cpme_pkg::VALID_BIT] && mapCnt[n] != 8'h00;
			if (rxHit[n]) begin
				next_rxBuf[n] = rxData;
				if (ttype[n] <= cpme_pkg::TT_SYNC_MAX) next_rxHeld[n] = 1'b1;
				else next_rxPend[n] = 1'b1;
			end
		end
		if (!opState) begin
			next_rxHeld = '0;
			next_rxPend = '0;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wState <= cpme_pkg::W_IDLE;
			{wMap, wEnt, wOff, wData, rxHeld, rxPend} <= '0;
			for (int n = 0; n < 8; n++) rxBuf[n] <= '0;
			{commitValid, commitIndex, commitSub, commitBits, commitData} <= '0;
		end else begin
			wState <= next_wState;
			wMap <= next_wMap;
			wEnt <= next_wEnt;
			wOff <= next_wOff;
			wData <= next_wData;
			rxBuf <= next_rxBuf;
			rxHeld <= next_rxHeld;
			rxPend <= next_rxPend;
			commitValid <= next_cValid;
			commitData <= next_cData;
			if (next_cValid) {commitIndex, commitSub, commitBits} <= memQ;
		end
	end

	// ----------------------------------------
	// transmit triggers, timers and arbitration
	// ----------------------------------------
	logic [63:0] frame [8], next_frame [8], lastSent [8], next_lastSent [8];
	logic [7:0] pend, next_pend, evtExp, txGrant;
	logic [7:0] syncCnt [8], next_syncCnt [8];
	logic [15:0] inhCnt [8], next_inhCnt [8], evtCnt [8], next_evtCnt [8];
	logic [11:0] tickCnt, next_tickCnt, txBits;
	logic [3:0] msCnt, next_msCnt;
	logic opPrev, tick, msTick, found, txEn, txEv, rtrHit, next_txValid;
	logic [2:0] g;
	logic [7:0] tt;

	assign tick = tickCnt == 12'(cpme_pkg::TICK_CYC - 1);
	assign msTick = tick && msCnt == 4'(cpme_pkg::TICKS_PER_MS - 1);

	always_comb begin
		next_frame = frame;
		next_lastSent = lastSent;
		next_pend = pend;
		next_syncCnt = syncCnt;
		next_inhCnt = inhCnt;
		next_evtCnt = evtCnt;
		next_tickCnt = tick ? '0 : tickCnt + 12'h1;
		next_msCnt = msTick ? '0 : (tick ? msCnt + 4'h1 : msCnt);
		next_txValid = txValid && !txReady;
		evtExp = '0;
		txGrant = '0;
		found = 1'b0;
		g = '0;
		txBits = '0;
		for (int k = 0; k < 8; k++) begin
			if (tick && inhCnt[k] != 16'h0) next_inhCnt[k] = inhCnt[k] - 16'h1;
			if (evtMs[k] == 16'h0) begin
				next_evtCnt[k] = '0;
			end else if (evtCnt[k] == 16'h0) begin
				next_evtCnt[k] = evtMs[k];
			end else if (msTick) begin
				evtExp[k] = evtCnt[k] == 16'h1;
				next_evtCnt[k] = evtExp[k] ? evtMs[k] : evtCnt[k] - 16'h1;
			end
		end
		for (int k = 7; k >= 0; k--) begin
			if (pend[k] && inhCnt[k] == 16'h0 && opState) begin
				found = 1'b1;
				g = 3'(k);
			end
		end
		for (int i = 0; i < 15; i++) begin
			if (8'(i) < mapCnt[{1'b1, g}]) txBits = txBits + {4'h0, entBits[{1'b1, g}][i]};
		end
		if (found && (!txValid || txReady)) begin
			txGrant[g] = 1'b1;
			next_txValid = 1'b1;
			next_lastSent[g] = frame[g];
			next_pend[g] = 1'b0;
			if (ttype[{1'b1, g}] >= cpme_pkg::TT_ASYNC) next_inhCnt[g] = inhibit[g];
		end
		for (int k = 0; k < 8; k++) begin
			tt = ttype[8 + k];
			txEn = opState && !cobId[8 + k][cpme_pkg::VALID_BIT] && mapCnt[8 + k] != 8'h00;
			// compare with the frame being sent now, so a grant raises no false change
			txEv = (opState && !opPrev) || evtExp[k]
				|| txObjData[k*64 +: 64] != next_lastSent[k];
			rtrHit = rxValid && rxRtr && rxId == actId[8 + k];
			if (!txEn) begin
				next_pend[k] = 1'b0;
				next_syncCnt[k] = '0;
			end else if (tt == cpme_pkg::TT_ACYCLIC) begin
				if (syncSeen) next_frame[k] = txObjData[k*64 +: 64];
				if (txEv) next_pend[k] = 1'b1;
			end else if (tt <= cpme_pkg::TT_SYNC_MAX) begin
				if (syncSeen) begin
					next_syncCnt[k] = syncCnt[k] + 8'h1;
					if (syncCnt[k] + 8'h1 == tt) begin
						next_frame[k] = txObjData[k*64 +: 64];
						next_pend[k] = 1'b1;
						next_syncCnt[k] = '0;
					end
				end
			end else if (tt == cpme_pkg::TT_RTR_SYNC) begin
				if (syncSeen) next_frame[k] = txObjData[k*64 +: 64];
				if (rtrHit) next_pend[k] = 1'b1;
			end else if (tt == cpme_pkg::TT_RTR_EVT) begin
				if (rtrHit) begin
					next_frame[k] = txObjData[k*64 +: 64];
					next_pend[k] = 1'b1;
				end
			end else if (tt >= cpme_pkg::TT_ASYNC && txEv) begin
				next_frame[k] = txObjData[k*64 +: 64];
				next_pend[k] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int k = 0; k < 8; k++) begin
				{frame[k], lastSent[k], syncCnt[k], inhCnt[k], evtCnt[k]} <= '0;
			end
			{pend, tickCnt, msCnt, opPrev} <= '0;
			{txValid, txId, txLen, txData} <= '0;
		end else begin
			frame <= next_frame;
			lastSent <= next_lastSent;
			pend <= next_pend;
			syncCnt <= next_syncCnt;
			inhCnt <= next_inhCnt;
			evtCnt <= next_evtCnt;
			tickCnt <= next_tickCnt;
			msCnt <= next_msCnt;
			opPrev <= opState;
			txValid <= next_txValid;
			if (txGrant != 8'h00) begin
				txId <= actId[{1'b1, g}];
				txLen <= 4'((txBits + 12'h7) >> 3);
				txData <= frame[g];
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_opOnly;
		@(posedge ref_clk) disable iff (sys_rst) $rose(txValid) |-> $past(opState);
	endproperty
	a_opOnly: assert property (p_opOnly) else $error("frame started outside operational");
	property p_opWrite;
		@(posedge ref_clk) disable iff (sys_rst) reqV && reqWr && opState && (reqComm || reqMap)
			&& reqSub <= reqTop |=> odDone && odAbort == cpme_pkg::ABORT_STATE;
	endproperty
	a_opWrite: assert property (p_opWrite) else $error("operational write not refused");
	property p_txFixedId;
		@(posedge ref_clk) disable iff (sys_rst) restartLd
			|=> actId[8] == cpme_pkg::TX_BASE[0] + {4'h0, $past(nodeId)};
	endproperty
	a_txFixedId: assert property (p_txFixedId) else $error("fixed transmit id wrong");
	property p_idHold;
		@(posedge ref_clk) disable iff (sys_rst) !restartLd |=> $stable(actId[12]);
	endproperty
	a_idHold: assert property (p_idHold) else $error("identifier changed without restart");
	property p_ttRsv;
		@(posedge ref_clk) disable iff (sys_rst) reqV && reqWr && !opState && reqComm
			&& reqSub == cpme_pkg::SUB_TTYPE && ttRsv
			|-> next_ttype[reqM] == ttype[reqM] ##1 odAbort == cpme_pkg::ABORT_GENERAL;
	endproperty
	a_ttRsv: assert property (p_ttRsv) else $error("reserved type accepted");
	property p_exceed;
		@(posedge ref_clk) disable iff (sys_rst) reqV && reqWr && !opState && reqMap
			&& reqSub == cpme_pkg::SUB_COUNT && reqData[7:0] <= cpme_pkg::MAX_ENTRY
			&& newSum > 12'(cpme_pkg::MAX_BITS) |=> odAbort == cpme_pkg::ABORT_EXCEED;
	endproperty
	a_exceed: assert property (p_exceed) else $error("oversized mapping accepted");
	property p_syncHold;
		@(posedge ref_clk) disable iff (sys_rst) rxHit[0] && !syncSeen
			&& ttype[0] <= cpme_pkg::TT_SYNC_MAX |=> rxHeld[0];
	endproperty
	a_syncHold: assert property (p_syncHold) else $error("sync payload not held");
	property p_asyncCommit;
		@(posedge ref_clk) disable iff (sys_rst) rxHit[0] && ttype[0] >= cpme_pkg::TT_ASYNC
			|=> rxPend[0];
	endproperty
	a_asyncCommit: assert property (p_asyncCommit) else $error("async payload not queued");
	property p_inhLoad;
		@(posedge ref_clk) disable iff (sys_rst) txGrant[0] && ttype[8] >= cpme_pkg::TT_ASYNC
			|=> inhCnt[0] == $past(inhibit[0]);
	endproperty
	a_inhLoad: assert property (p_inhLoad) else $error("inhibit not loaded");
	property p_inhBlock;
		@(posedge ref_clk) disable iff (sys_rst) inhCnt[0] != 16'h0 |-> !txGrant[0];
	endproperty
	a_inhBlock: assert property (p_inhBlock) else $error("sent inside inhibit gap");
	property p_evtReload;
		@(posedge ref_clk) disable iff (sys_rst) msTick && evtCnt[0] == 16'h1 && evtMs[0] != 16'h0
			|=> evtCnt[0] == $past(evtMs[0]);
	endproperty
	a_evtReload: assert property (p_evtReload) else $error("event timer not reloaded");
endmodule : cpme_engine
`default_nettype wire

// *** tb/cpme_master_model.sv ***
// master-side model: frames, sync pulses and frame acceptance
`default_nettype none
module cpme_master_model #(
	parameter int STALL = 3
) (
	input wire logic ref_clk,
	input wire logic txValid,
	input wire logic [10:0] txId,
	input wire logic [3:0] txLen,
	input wire logic [63:0] txData,
	output logic txReady,
	output logic rxValid,
	output logic [10:0] rxId,
	output logic rxRtr,
	output logic [63:0] rxData,
	output logic syncSeen
);
	timeunit 1ns;
	timeprecision 1ps;
	int frames = 0;
	int waitCnt = 0;
	logic [10:0] lastId = 11'h000;
	logic [3:0] lastLen = 4'h0;
	logic [63:0] lastData = 64'h0;
	initial begin
		rxValid = 1'b0;
		rxId = 11'h555;
		rxRtr = 1'b0;
		rxData = 64'hA5A5_5A5A_A5A5_5A5A;
		syncSeen = 1'b0;
	end
	// idle lines except rxRtr show the inverse, never the last frame
	task automatic sendFrame(input logic [10:0] id, input logic rtr, input logic [63:0] d);
		@(posedge ref_clk);
		#1;
		rxValid = 1'b1;
		rxId = id;
		rxRtr = rtr;
		rxData = d;
		@(posedge ref_clk);
		#1;
		rxValid = 1'b0;
		rxId = ~id;
		rxData = ~d;
	endtask : sendFrame
	task automatic sendSync();
		@(posedge ref_clk);
		#1;
		syncSeen = 1'b1;
		@(posedge ref_clk);
		#1;
		syncSeen = 1'b0;
	endtask : sendSync
	// slow acceptance: stall before taking each frame
	always @(posedge ref_clk) begin
		txReady <= txValid && !txReady && waitCnt >= STALL;
		if (txValid && txReady) begin
			frames <= frames + 1;
			lastId <= txId;
			lastLen <= txLen;
			lastData <= txData;
			waitCnt <= 0;
		end else if (txValid && waitCnt < STALL) begin
			waitCnt <= waitCnt + 1;
		end
	end
endmodule : cpme_master_model
`default_nettype wire

// *** tb/cpme_engine_tb.sv ***
// self-checking bench of the pdo mapping engine
`default_nettype none
`define CHK(nm, e, a) begin checkCount++; if ((a) !== (e)) begin errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, a); end end
module cpme_engine_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic opState = 1'b0;
	logic commRestart = 1'b0;
	logic odWrite = 1'b0;
	logic odRead = 1'b0;
	logic [15:0] odIndex = 16'h0;
	logic [7:0] odSub = 8'h0;
	logic [31:0] odWdata = 32'h0;
	logic odDone, rxValid, rxRtr, syncSeen, txValid, txReady, commitValid;
	logic [31:0] odRdata, odAbort;
	logic [10:0] rxId, txId;
	logic [63:0] rxData, txData, commitData;
	logic [3:0] txLen;
	logic [15:0] commitIndex;
	logic [7:0] commitSub, commitBits;
	int errors = 0;
	int checkCount = 0;
	initial forever #12.5 ref_clk = ~ref_clk;
	cpme_engine DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .nodeIdPin(7'h05),
		.opState(opState), .commRestart(commRestart), .odWrite(odWrite), .odRead(odRead),
		.odIndex(odIndex), .odSub(odSub), .odWdata(odWdata), .odDone(odDone),
		.odRdata(odRdata), .odAbort(odAbort), .rxValid(rxValid), .rxId(rxId),
		.rxRtr(rxRtr), .rxData(rxData), .syncSeen(syncSeen),
		.txObjData({8{64'h0123_4567_89AB_CDEF}}), .txValid(txValid), .txReady(txReady),
		.txId(txId), .txLen(txLen), .txData(txData), .commitValid(commitValid),
		.commitIndex(commitIndex), .commitSub(commitSub), .commitBits(commitBits),
		.commitData(commitData));
	cpme_master_model master (.ref_clk(ref_clk), .txValid(txValid), .txId(txId),
		.txLen(txLen), .txData(txData), .txReady(txReady), .rxValid(rxValid),
		.rxId(rxId), .rxRtr(rxRtr), .rxData(rxData), .syncSeen(syncSeen));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, input logic [31:0] expAb, input logic [31:0] expRd);
		int n;
		@(posedge ref_clk);
		#1;
		odWrite = wr;
		odRead = !wr;
		odIndex = idx;
		odSub = sub;
		odWdata = wd;
		@(posedge ref_clk);
		#1;
		odWrite = 1'b0;
		odRead = 1'b0;
		n = 1;
		while (odDone !== 1'b1 && n < 8) begin @(posedge ref_clk); #1; n++; end
		`CHK("odLatency", 2, n)
		`CHK("odAbort", expAb, odAbort)
		`CHK("odRdata", expRd, odRdata)
	endtask : od
	task automatic waitCommit(input logic [31:0] ent, input logic [63:0] d);
		int n;
		n = 0;
		while (commitValid !== 1'b1 && n < 20) begin @(posedge ref_clk); #1; n++; end
		`CHK("commitValid", 1'b1, commitValid)
		`CHK("commitIndex", ent[31:16], commitIndex)
		`CHK("commitSub", ent[15:8], commitSub)
		`CHK("commitBits", ent[7:0], commitBits)
		`CHK("commitData", d, commitData)
		@(posedge ref_clk);
		#1;
	endtask : waitCommit
	task automatic expectQuiet();
		int n;
		n = 0;
		while (commitValid !== 1'b1 && n < 10) begin @(posedge ref_clk); #1; n++; end
		`CHK("quietCycles", 10, n)
	endtask : expectQuiet
	initial begin
		#(25 * 20000);
		errors++;
		complete_run();
	end
	initial begin
		int n;
		repeat (16) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		repeat (4) @(posedge ref_clk);
		od(0, 16'h1400, 8'h00, 32'h0, cpme_pkg::ABORT_NONE, 32'h2);
		od(0, 16'h1400, 8'h03, 32'h0, cpme_pkg::ABORT_NOSUB, 32'h0);
		od(0, 16'h1800, 8'h00, 32'h0, cpme_pkg::ABORT_NONE, 32'h5);
		od(1, 16'h1800, 8'h04, 32'h1234, cpme_pkg::ABORT_NONE, 32'h0);
		od(0, 16'h1C00, 8'h00, 32'h0, cpme_pkg::ABORT_NOOBJ, 32'h0);
		$display("test access done");
		od(1, 16'h1600, 8'h01, 32'h6040_0010, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1600, 8'h02, 32'h607A_0020, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1600, 8'h03, 32'h6000_0040, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1600, 8'h00, 32'h3, cpme_pkg::ABORT_EXCEED, 32'h0);
		od(1, 16'h1600, 8'h00, 32'h10, cpme_pkg::ABORT_VALUE, 32'h0);
		od(1, 16'h1600, 8'h00, 32'h2, cpme_pkg::ABORT_NONE, 32'h0);
		od(0, 16'h1600, 8'h01, 32'h0, cpme_pkg::ABORT_NONE, 32'h6040_0010);
		od(1, 16'h1400, 8'h02, 32'hF5, cpme_pkg::ABORT_GENERAL, 32'h0);
		od(0, 16'h1400, 8'h02, 32'h0, cpme_pkg::ABORT_NONE, 32'hFF);
		od(1, 16'h1400, 8'h02, 32'hFE, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1400, 8'h01, 32'h7FF, cpme_pkg::ABORT_NONE, 32'h0);
		od(0, 16'h1400, 8'h01, 32'h0, cpme_pkg::ABORT_NONE, 32'h205);
		od(1, 16'h1A00, 8'h01, 32'h6041_0010, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1A00, 8'h00, 32'h1, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1800, 8'h02, 32'h1, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1800, 8'h01, 32'h0, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1404, 8'h01, 32'h123, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1404, 8'h02, 32'h0, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1604, 8'h01, 32'h2000_0108, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1604, 8'h00, 32'h1, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1A01, 8'h01, 32'h6064_0020, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1A01, 8'h00, 32'h1, cpme_pkg::ABORT_NONE, 32'h0);
		od(1, 16'h1801, 8'h01, 32'h0, cpme_pkg::ABORT_NONE, 32'h0);
		$display("test configure done");
		opState = 1'b1;
		od(1, 16'h1600, 8'h00, 32'h1, cpme_pkg::ABORT_STATE, 32'h0);
		od(0, 16'h1600, 8'h00, 32'h0, cpme_pkg::ABORT_NONE, 32'h2);
		master.sendFrame(11'h205, 1'b0, 64'h0000_5566_7788_1234);
		waitCommit(32'h6040_0010, 64'h1234);
		waitCommit(32'h607A_0020, 64'h5566_7788);
		master.sendFrame(11'h123, 1'b0, 64'h1122_3344_5566_77AB);
		expectQuiet();
		@(posedge ref_clk);
		#1;
		commRestart = 1'b1;
		@(posedge ref_clk);
		#1;
		commRestart = 1'b0;
		master.sendFrame(11'h123, 1'b0, 64'h1122_3344_5566_77AB);
		expectQuiet();
		master.sendSync();
		waitCommit(32'h2000_0108, 64'hAB);
		$display("test receive done");
		n = 0;
		while (master.frames < 2 && n < 40) begin @(posedge ref_clk); #1; n++; end
		`CHK("frames", 2, master.frames)
		`CHK("txId", 11'h185, master.lastId)
		`CHK("txLen", 4'h2, master.lastLen)
		`CHK("txData", 16'hCDEF, master.lastData[15:0])
		$display("test transmit done");
		complete_run();
	end
endmodule : cpme_engine_tb
`default_nettype wire
